// File: design/srbsb_pkg.sv
// Purpose: Constants, carriers and helpers for the serial readback and status bank.
// Assumes: Fault, ramp and check inputs arrive already on the system clock.
// Notes:

package srbsb_pkg;

	localparam int            CMD_LAST      = 23;
	localparam int            CHK_LAST      = 31;
	localparam int            CMD_BYTE_LAST = 7;
	localparam int            DATA_W        = 16;
	localparam int            SEL_W         = 5;
	localparam int            CMD_RW_BIT    = 7;
	localparam int            CMD_ADDR_MSB  = 6;
	localparam int            CMD_ADDR_LSB  = 5;
	localparam logic [4:0]    SEL_SLEW_A    = 5'h14;
	localparam logic [4:0]    SEL_STATUS    = 5'h18;
	localparam logic [4:0]    SEL_MAIN      = 5'h19;
	localparam logic [4:0]    SEL_LAST      = 5'h1a;
	localparam logic [23:0]   NOP_WORD      = 24'h3ce000;
	localparam int            SLEW_EN_BIT   = 12;
	localparam logic [15:0]   SLEW_KEEP     = 16'h107f;
	localparam int            MAIN_AUTO_BIT = 0;
	localparam int            MAIN_CHK_BIT  = 1;
	localparam int            ST_CHK_EN     = 11;
	localparam int            ST_CHK_ERR    = 10;
	localparam int            ST_RAMP       = 9;
	localparam int            ST_OTEMP      = 8;
	localparam logic [15:0]   STATUS_RST    = 16'h0000;
	localparam logic [31:0]   RESP_RST      = 32'h0000_0000;
	localparam logic [7:0]    CRC_POLY      = 8'h07;

	typedef struct packed {
		logic       valid;
		logic [4:0] sel;
		logic [15:0] data;
	} srbsb_wr_t;

	typedef struct packed {
		logic [3:0] current_mode;
		logic [3:0] comp_lost;
		logic [3:0] reg_fail;
		logic [3:0] vout_fault;
		logic [3:0] iout_fault;
		logic [3:0] slewing;
		logic       overtemp;
	} srbsb_flt_t;

	typedef struct packed {
		logic done;
		logic bad;
	} srbsb_chk_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_LOAD  = 2'b10
	} srbsb_state_t;

	function automatic logic [7:0] srbsb_crc8(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction : srbsb_crc8

	function automatic logic srbsb_is_slew(input logic [4:0] sel);
		return sel[4:2] == SEL_SLEW_A[4:2];
	endfunction : srbsb_is_slew

endpackage : srbsb_pkg

// File: design/srbsb_regmem.sv
// Purpose: Register mirror indexed by the read selector.
// Assumes: One write and one read per cycle.
// Notes: Read data is registered, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module srbsb_regmem #(
	parameter int AW    = 5,
	parameter int WIDTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_waddr,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic [AW-1:0]    i_raddr,
	output logic      [WIDTH-1:0] o_rdata
);

	logic [WIDTH-1:0] mem_r [0:(1<<AW)-1];

	if (AW < 1 || WIDTH < 1)
		$error("AW and WIDTH must be at least one.");

	always_ff @(posedge i_clk)
		if (i_we)
			mem_r[i_waddr] <= i_wdata;

	always_ff @(posedge i_clk)
		if (i_rst)
			o_rdata <= '0;
		else
			o_rdata <= mem_r[i_raddr];

endmodule : srbsb_regmem

`default_nettype wire

// File: design/srbsb_sync.sv
// Purpose: Two-stage synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module srbsb_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_r;

	if (WIDTH < 1)
		$error("WIDTH must be at least one.");

	always_ff @(posedge i_clk)
	begin
		meta_r <= i_d;
		o_q    <= meta_r;
	end

endmodule : srbsb_sync

`default_nettype wire

// File: design/srbsb_top.sv
// Purpose: Serial readback path, status register and slew register storage.
// Assumes: Host drives SDIN after falling SCLK; device samples on rising SCLK.
// Notes: The answer to a frame is prepared between frames on the system clock.
`timescale 1ns/1ps
`default_nettype none

module srbsb_top (
	input  wire logic               I_CLK,
	input  wire logic               I_SYS_RST,
	input  wire logic               I_SCLK,
	input  wire logic               I_SYNC_N,
	input  wire logic               I_SDIN,
	input  wire logic [1:0]         I_DEV_ADDR,
	input  wire srbsb_pkg::srbsb_wr_t  I_REG_WR,
	input  wire srbsb_pkg::srbsb_flt_t I_FLT,
	input  wire srbsb_pkg::srbsb_chk_t I_CHK,
	output logic                    O_SDO,
	output logic                    O_FAULT_O,
	output logic                    O_FAULT_OE,
	output logic [15:0]             O_STATUS,
	output logic                    O_CHK_EN,
	output logic                    O_AUTOREAD
);

	import srbsb_pkg::*;

	// Link-domain state.
	logic [1:0]        lsync_q;
	logic              lrst;
	logic              chk_en_l;
	logic [4:0]        bit_cnt_r;
	logic [4:0]        bit_last;
	logic [6:0]        in_sh_r;
	logic [7:0]        cmd_l_r;
	logic              req_tgl_r;

	// System-domain state.
	logic [2:0]        ssync_q;
	logic              req_s;
	logic [1:0]        dev_s;
	logic              req_d_r;
	logic              req_ev;
	srbsb_state_t      state_r;
	logic [7:0]        cmd_r;
	logic [31:0]       resp_r;
	logic [15:0]       status_r;
	logic [15:0]       word_nxt;
	logic              is_rd;
	logic              chk_en_r;
	logic              autoread_r;
	logic              chk_err_r;
	logic [3:0]        slew_en_r;
	logic              fault_r;
	logic              mem_we;
	logic [15:0]       mem_wdata;
	logic [15:0]       mem_q;
	logic [3:0]        boost_flag;
	logic [3:0]        iout_flag;
	logic              wr_slew;

	// The link reset is released only on SCLK edges, so the host gives a few idle clocks first.
	srbsb_sync #(.WIDTH(2)) u_lsync (
		.i_clk (I_SCLK),
		.i_d   ({I_SYS_RST, chk_en_r}),
		.o_q   (lsync_q)
	);
	assign lrst     = lsync_q[1];
	assign chk_en_l = lsync_q[0];

	srbsb_sync #(.WIDTH(3)) u_ssync (
		.i_clk (I_CLK),
		.i_d   ({req_tgl_r, I_DEV_ADDR}),
		.o_q   (ssync_q)
	);
	assign req_s = ssync_q[2];
	assign dev_s = ssync_q[1:0];

	assign bit_last = chk_en_l ? 5'(CHK_LAST) : 5'(CMD_LAST);

	always_ff @(posedge I_SCLK)
		if (lrst || I_SYNC_N)
			bit_cnt_r <= 5'h00;
		else if (bit_cnt_r == bit_last)
			bit_cnt_r <= 5'h00;
		else
			bit_cnt_r <= bit_cnt_r + 5'h01;

	always_ff @(posedge I_SCLK)
		if (lrst)
			in_sh_r <= 7'h00;
		else if (!I_SYNC_N)
			in_sh_r <= {in_sh_r[5:0], I_SDIN};

	// Only the command byte matters for readback; the data bits are not kept.
	always_ff @(posedge I_SCLK)
		if (lrst)
			cmd_l_r <= 8'h00;
		else if (!I_SYNC_N && bit_cnt_r == 5'(CMD_BYTE_LAST))
			cmd_l_r <= {in_sh_r, I_SDIN};

	// The request is raised on the frame's last bit, so a new answer never lands mid-frame.
	always_ff @(posedge I_SCLK)
		if (lrst)
			req_tgl_r <= 1'b0;
		else if (!I_SYNC_N && bit_cnt_r == bit_last)
			req_tgl_r <= ~req_tgl_r;

	// The answer word is held still on the system side for the whole frame.
	always_ff @(posedge I_SCLK)
		if (lrst)
			O_SDO <= 1'b0;
		else if (!I_SYNC_N)
			O_SDO <= resp_r[~bit_cnt_r];

	// System domain.
	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			req_d_r <= 1'b0;
		else
			req_d_r <= req_s;
	assign req_ev = req_s ^ req_d_r;

	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			cmd_r <= 8'h00;
		else if (req_ev)
			cmd_r <= cmd_l_r;

	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			state_r <= ST_IDLE;
		else
			case (state_r)
				ST_IDLE:  state_r <= req_ev ? ST_FETCH : ST_IDLE;
				ST_FETCH: state_r <= ST_LOAD;
				ST_LOAD:  state_r <= ST_IDLE;
				default:  state_r <= ST_IDLE;
			endcase

	assign is_rd = cmd_r[CMD_RW_BIT] && cmd_r[CMD_ADDR_MSB:CMD_ADDR_LSB] == dev_s;

	always_comb
	begin
		word_nxt = 16'h0000;
		if (is_rd)
		begin
			if (cmd_r[4:0] == SEL_STATUS)
				word_nxt = status_r;
			else if (cmd_r[4:0] <= SEL_LAST)
				word_nxt = mem_q;
		end
		else if (autoread_r)
			word_nxt = status_r;
		else
			word_nxt = 16'h0000;
	end

	// Upper byte is don't-care and driven low; the check byte is sent only when checking is on.
	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			resp_r <= RESP_RST;
		else if (state_r == ST_LOAD)
			resp_r <= {8'h00, word_nxt,
				chk_en_r ? srbsb_crc8({8'h00, word_nxt}) : 8'h00};

	// Write filtering: status cannot be written, slew words with nonzero top bits are dropped.
	assign wr_slew   = I_REG_WR.valid && srbsb_is_slew(I_REG_WR.sel);
	assign mem_we    = I_REG_WR.valid && I_REG_WR.sel != SEL_STATUS && I_REG_WR.sel <= SEL_LAST
		&& !(wr_slew && I_REG_WR.data[15:13] != 3'h0);
	assign mem_wdata = wr_slew ? (I_REG_WR.data & SLEW_KEEP) : I_REG_WR.data;

	srbsb_regmem #(.AW(SEL_W), .WIDTH(DATA_W)) u_mem (
		.i_clk   (I_CLK),
		.i_rst   (I_SYS_RST),
		.i_we    (mem_we),
		.i_waddr (I_REG_WR.sel),
		.i_wdata (mem_wdata),
		.i_raddr (cmd_r[4:0]),
		.o_rdata (mem_q)
	);

	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			slew_en_r <= 4'h0;
		else if (mem_we && wr_slew)
			slew_en_r[I_REG_WR.sel[1:0]] <= I_REG_WR.data[SLEW_EN_BIT];

	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
		begin
			autoread_r <= 1'b0;
			chk_en_r   <= 1'b0;
		end
		else if (mem_we && I_REG_WR.sel == SEL_MAIN)
		begin
			autoread_r <= I_REG_WR.data[MAIN_AUTO_BIT];
			chk_en_r   <= I_REG_WR.data[MAIN_CHK_BIT];
		end

	// Follows each checked word, so a good word clears an earlier error.
	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			chk_err_r <= 1'b0;
		else if (I_CHK.done)
			chk_err_r <= I_CHK.bad;

	assign boost_flag = (I_FLT.current_mode & I_FLT.comp_lost)
		| (~I_FLT.current_mode & I_FLT.reg_fail);
	assign iout_flag  = I_FLT.iout_fault | (I_FLT.current_mode & I_FLT.comp_lost);

	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			status_r <= STATUS_RST;
		else
			status_r <= {boost_flag, chk_en_r, chk_err_r,
				|(I_FLT.slewing & slew_en_r), I_FLT.overtemp,
				I_FLT.vout_fault, iout_flag};

	// The pin looks at raw faults and the check error only, so a converter flag alone never pulls it.
	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			fault_r <= 1'b0;
		else
			fault_r <= |I_FLT.vout_fault || |I_FLT.iout_fault || chk_err_r
				|| I_FLT.overtemp;

	always_ff @(posedge I_CLK)
		if (I_SYS_RST)
			O_FAULT_O <= 1'b0;
		else
			O_FAULT_O <= 1'b0;

	assign O_FAULT_OE = fault_r;
	assign O_STATUS   = status_r;
	assign O_CHK_EN   = chk_en_r;
	assign O_AUTOREAD = autoread_r;

	// Checks on the system clock.
	property p_boost_quiet;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_FLT.vout_fault == 4'h0 && I_FLT.iout_fault == 4'h0 && !I_FLT.overtemp && !chk_err_r)
			|=> !O_FAULT_OE;
	endproperty
	a_boost_quiet: assert property (p_boost_quiet) else $error("Fault pin moved without fault.");

	property p_comp_lost;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_FLT.current_mode[0] && I_FLT.comp_lost[0]) |=> (O_STATUS[12] && O_STATUS[0]);
	endproperty
	a_comp_lost: assert property (p_comp_lost) else $error("Compliance loss not flagged.");

	property p_reg_fail;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(!I_FLT.current_mode[3] && I_FLT.reg_fail[3]) |=> O_STATUS[15];
	endproperty
	a_reg_fail: assert property (p_reg_fail) else $error("Regulation failure not flagged.");

	property p_status_ro;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_REG_WR.valid && I_REG_WR.sel == SEL_STATUS) |-> !mem_we;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("Status register written.");

	property p_slew_word;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(mem_we && wr_slew) |-> (mem_wdata[15:13] == 3'h0 && mem_wdata[11:7] == 5'h00);
	endproperty
	a_slew_word: assert property (p_slew_word) else $error("Bad slew word stored.");

	property p_read_status;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(state_r == ST_LOAD && is_rd && cmd_r[4:0] == SEL_STATUS)
			|=> resp_r[23:8] == $past(status_r) && resp_r[31:24] == 8'h00;
	endproperty
	a_read_status: assert property (p_read_status) else $error("Status readback wrong.");

	property p_read_mem;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(state_r == ST_LOAD && is_rd && cmd_r[4:0] < SEL_STATUS) |=> resp_r[23:8] == $past(mem_q);
	endproperty
	a_read_mem: assert property (p_read_mem) else $error("Register readback wrong.");

	property p_crc;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(state_r == ST_LOAD && chk_en_r) |=> resp_r[7:0] == srbsb_crc8(resp_r[31:8]);
	endproperty
	a_crc: assert property (p_crc) else $error("Check byte wrong.");

	property p_autoread;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(state_r == ST_LOAD && !is_rd) |=> resp_r[23:8] == ($past(autoread_r) ? $past(status_r) : 16'h0000);
	endproperty
	a_autoread: assert property (p_autoread) else $error("Write frame answer wrong.");

	property p_chk_err;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_CHK.done && I_CHK.bad) |=> ##1 O_STATUS[ST_CHK_ERR];
	endproperty
	a_chk_err: assert property (p_chk_err) else $error("Check error not shown.");

	property p_ramp;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		((I_FLT.slewing & slew_en_r) != 4'h0) |=> O_STATUS[ST_RAMP];
	endproperty
	a_ramp: assert property (p_ramp) else $error("Ramp bit missing.");

	// Checks on the link clock, then covers on both clocks.
	property p_msb_first;
		@(posedge I_SCLK) disable iff (lrst)
		(!I_SYNC_N && bit_cnt_r == 5'h00) |=> O_SDO == resp_r[31];
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("First bit not MSB.");

	property p_req;
		@(posedge I_SCLK) disable iff (lrst)
		(!I_SYNC_N && bit_cnt_r == bit_last) |=> req_tgl_r != $past(req_tgl_r);
	endproperty
	a_req: assert property (p_req) else $error("Request not raised.");

	c_read_status: cover property (@(posedge I_CLK) disable iff (I_SYS_RST)
		state_r == ST_LOAD && is_rd && cmd_r[4:0] == SEL_STATUS);
	c_autoread: cover property (@(posedge I_CLK) disable iff (I_SYS_RST)
		state_r == ST_LOAD && !is_rd && autoread_r);
	c_chk_frame: cover property (@(posedge I_SCLK) disable iff (lrst)
		chk_en_l && bit_cnt_r == 5'(CHK_LAST));
	c_slew_write: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) mem_we && wr_slew);

endmodule : srbsb_top

`default_nettype wire

// File: verification/srbsb_host.sv
// Purpose: Host serial controller model facing the readback bank.
// Assumes: Serial clock stands still between frames.
// Notes: The idle data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none

module srbsb_host (
	input  wire logic i_sdo,
	output logic      o_sclk,
	output logic      o_sync_n,
	output logic      o_sdin
);
	initial
	begin
		o_sclk   = 1'b0;
		o_sync_n = 1'b1;
		o_sdin   = 1'b0;
	end

	function automatic logic [7:0] crc8(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8

	task automatic tick(input int n);
		repeat (n)
		begin
			#7.5 o_sclk = 1'b1;
			#7.5 o_sclk = 1'b0;
		end
	endtask : tick

	// A checked frame carries its own CRC byte after the command.
	task automatic xfer(input logic [23:0] cmd, input logic chk, output logic [31:0] rx);
		logic [31:0] w;
		w = {cmd, crc8(cmd)};
		rx = 32'h0;
		o_sync_n = 1'b0;
		for (int k = 0; k < (chk ? 32 : 24); k++)
		begin
			o_sdin = w[31-k];
			tick(1);
			rx = {rx[30:0], i_sdo};
		end
		#7.5 o_sync_n = 1'b1;
		o_sdin = ~o_sdin;
		// The gap gives the system side time to prepare the answer.
		#150;
	endtask : xfer
endmodule : srbsb_host

`default_nettype wire

// File: verification/testbench.sv
// Purpose: Self-checking bench for the serial readback and status bank.
// Assumes: Device address straps tied to 01.
// Notes: Expected words come from the field layout, never from the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end

module testbench;
	import srbsb_pkg::*;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	srbsb_wr_t        wrq = '0;
	srbsb_flt_t       flt = '0;
	srbsb_chk_t       chk = '0;
	wire logic        sclk, sync_n, sdin, sdo, f_o, f_oe, chk_en, autord;
	wire logic [15:0] status;
	int               n_errors = 0;
	int               num_checks = 0;
	logic             packet_check = 1'b0;
	logic [31:0]      rx;
	logic [4:0]       sels [8] = '{5'h00, 5'h05, 5'h0a, 5'h0f, 5'h10, 5'h13, 5'h0c, 5'h1a};

	always #5 clk = ~clk;

	srbsb_host i_host (.i_sdo(sdo), .o_sclk(sclk), .o_sync_n(sync_n), .o_sdin(sdin));

	srbsb_top i_dut (
		.I_CLK(clk), .I_SYS_RST(rst), .I_SCLK(sclk), .I_SYNC_N(sync_n),
		.I_SDIN(sdin), .I_DEV_ADDR(2'b01), .I_REG_WR(wrq), .I_FLT(flt),
		.I_CHK(chk), .O_SDO(sdo), .O_FAULT_O(f_o), .O_FAULT_OE(f_oe),
		.O_STATUS(status), .O_CHK_EN(chk_en), .O_AUTOREAD(autord)
	);

	function automatic logic [15:0] exp_st(input logic ce, input logic [3:0] sen);
		logic [3:0] m;
		m = flt.current_mode;
		return {(m & flt.comp_lost) | (~m & flt.reg_fail), ce, 1'b0,
			|(flt.slewing & sen), flt.overtemp, flt.vout_fault,
			flt.iout_fault | (m & flt.comp_lost)};
	endfunction : exp_st

	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle

	task automatic wr(input logic [4:0] s, input logic [15:0] d);
		@(posedge clk);
		#1 wrq = {1'b1, s, d};
		@(posedge clk);
		#1 wrq.valid = 1'b0;
		settle;
	endtask : wr

	task automatic rd(input logic [4:0] s, input logic [15:0] e);
		i_host.xfer({1'b1, 2'b01, s, 16'h0000}, packet_check, rx);
		i_host.xfer(NOP_WORD, packet_check, rx);
		if (packet_check)
		begin
			`CHK(rx[23:8], e)
			`CHK(rx[7:0], i_host.crc8({8'h00, e}))
		end
		else
			`CHK(rx[15:0], e)
	endtask : rd

	task automatic pulse(input logic bad, input logic e);
		chk = {1'b1, bad};
		@(posedge clk);
		#1 chk = '0;
		settle;
		`CHK(status[ST_CHK_ERR], e)
		`CHK(f_oe, e)
	endtask : pulse

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		#3 i_host.tick(4);
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		i_host.tick(4);
		foreach (sels[i]) wr(sels[i], 16'h0a50 + 16'(i));
		// Chained reads: each frame returns the word asked for by the one before.
		i_host.xfer({1'b1, 2'b01, sels[0], 16'h0000}, packet_check, rx);
		for (int i = 1; i < 8; i++)
		begin
			i_host.xfer({1'b1, 2'b01, sels[i], 16'h0000}, packet_check, rx);
			`CHK(rx[15:0], 16'h0a50 + 16'(i - 1))
		end
		i_host.xfer(NOP_WORD, packet_check, rx);
		`CHK(rx[15:0], 16'h0a57)
		wr(5'h14, 16'h0003);
		wr(5'h14, 16'h2fff);
		wr(5'h15, 16'h1fff);
		rd(5'h14, 16'h0003);
		rd(5'h15, 16'h107f);
		flt = '{current_mode: 4'h5, comp_lost: 4'hf, reg_fail: 4'ha, slewing: 4'h3, default: '0};
		settle;
		`CHK(status, exp_st(1'b0, 4'h2))
		`CHK(f_oe, 1'b0)
		rd(SEL_STATUS, exp_st(1'b0, 4'h2));
		wr(SEL_STATUS, 16'hffff);
		`CHK(status, exp_st(1'b0, 4'h2))
		flt.overtemp = 1'b1;
		flt.vout_fault = 4'h8;
		settle;
		`CHK(status, exp_st(1'b0, 4'h2))
		`CHK(f_oe, 1'b1)
		`CHK(f_o, 1'b0)
		flt.overtemp = 1'b0;
		flt.vout_fault = 4'h0;
		pulse(1'b1, 1'b1);
		pulse(1'b0, 1'b0);
		wr(SEL_MAIN, 16'h0001);
		`CHK(autord, 1'b1)
		repeat (2) i_host.xfer(NOP_WORD, packet_check, rx);
		`CHK(rx[15:0], exp_st(1'b0, 4'h2))
		wr(SEL_MAIN, 16'h0000);
		repeat (2) i_host.xfer(NOP_WORD, packet_check, rx);
		`CHK(rx[15:0], 16'h0000)
		// A read aimed at another device address must come back as a plain write answer.
		i_host.xfer({1'b1, 2'b10, 5'h0a, 16'h0000}, packet_check, rx);
		i_host.xfer(NOP_WORD, packet_check, rx);
		`CHK(rx[15:0], 16'h0000)
		wr(SEL_MAIN, 16'h0002);
		`CHK(chk_en, 1'b1)
		`CHK(status[ST_CHK_EN], 1'b1)
		i_host.tick(3);
		packet_check = 1'b1;
		rd(5'h0a, 16'h0a52);
		rd(SEL_STATUS, exp_st(1'b1, 4'h2));
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
